//--- pfseq_defs.svh
// Constants for the program flow sequencer: encodings and block offsets.
// Assumes inclusion by pfseq_core.sv and the bench only; pfseq_pkg.sv does not include it.
`ifndef PFSEQ_DEFS_SVH
`define PFSEQ_DEFS_SVH

// Program control opcodes (instruction bits 3:0 of the control field)
`define PFSEQ_PC_CONT     4'h0
`define PFSEQ_PC_JMP      4'h1
`define PFSEQ_PC_JMP_LC   4'h2
`define PFSEQ_PC_JMP_FIFO 4'h3
`define PFSEQ_PC_JMP_TOS  4'h4
`define PFSEQ_PC_CONDITIONAL_JUMP_OP     4'h5
`define PFSEQ_PC_INVERSE_CONDITIONAL_JUMP_OP    4'h6
`define PFSEQ_PC_CASE     4'h7
`define PFSEQ_PC_JPI      4'h8

// Data operations
`define PFSEQ_OP_NOP      2'h0
`define PFSEQ_OP_INV      2'h1
`define PFSEQ_OP_INC      2'h2

// Destination classes
`define PFSEQ_DST_GEN     3'h0
`define PFSEQ_DST_DOUT    3'h1
`define PFSEQ_DST_ACH     3'h2
`define PFSEQ_DST_ACL     3'h3
`define PFSEQ_DST_BC      3'h4
`define PFSEQ_DST_Q       3'h5

// Condition code selector values
`define PFSEQ_CC_INTERRUPT_PENDING_FLAG     5'h00
`define PFSEQ_CC_BCZ      5'h01
`define PFSEQ_CC_FA       5'h02
`define PFSEQ_CC_FB       5'h03
`define PFSEQ_CC_Z        5'h04
`define PFSEQ_CC_O        5'h05
`define PFSEQ_CC_S        5'h06
`define PFSEQ_CC_CY       5'h07
`define PFSEQ_CC_ACO      5'h08
`define PFSEQ_CC_FC       5'h09
`define PFSEQ_CC_FD       5'h0A
`define PFSEQ_CC_STACK_FULL_FLAG     5'h0B
`define PFSEQ_CC_DOR      5'h0C
`define PFSEQ_CC_USER     5'h10

// Block offsets
`define PFSEQ_JPI_IDLE    4'h0
`define PFSEQ_JPI_BASE    4'h8
`define PFSEQ_PC_RESET    10'h000

`endif

//--- pfseq_pkg.sv
// Types for the program flow sequencer.
// Does not include pfseq_defs.svh; needs no include path.
package pfseq_pkg;
  typedef enum logic [1:0] {
    PFSEQ_ST_RUN  = 2'b01,
    PFSEQ_ST_HALT = 2'b10
  } pfseq_state_t;

  typedef struct packed {
    pfseq_state_t state;
    logic [9:0]   pc;
    logic [15:0]  gen_q;
    logic [15:0]  dout;
    logic [15:0]  accumulator_high;
    logic [15:0]  accumulator_low;
    logic [15:0]  bc;
    logic         f_z;
    logic         f_cy;
    logic         f_s;
    logic         f_o;
    logic         f_aco;
    logic         f_dor;
    logic         f_bcz;
    logic         fifo_pop;
    logic [15:0]  out_ctl;
  } pfseq_regs_t;
endpackage

//--- pfseq_core.sv
// Program flow sequencer: data ops, flags and next program counter.
// Assumes an external program memory, register file, FIFO and stack;
// pins from outside the clock domain are synchronised here.
//
// Operation
// - One-operand complement inverts destination in place
// - Two-operand complement writes inverted source
// - Results update arithmetic and destination flags
// - Source operand encoding uses general or Q
// - Case selector formed from chosen group
// - Case jump goes to base plus selector
// - Case entry without jump falls through
// - Label jump loads encoded target
// - Loop pointer jump loads ten-bit counter
// - FIFO jump takes head, pops FIFO; falls through when FIFO empty
// - Stack jump reads top, stack untouched
// - Conditional jump branches when code true
// - Inverse jump branches when code false
// - Twenty-one selectable branch conditions
// - No interrupt: priority jump to first entry
// - Interrupt active: one of last eight
// - Priority jump only when interrupts disabled
// - Jumps leave condition flags untouched
// - Add-one forms mirror complement forms
`include "pfseq_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module pfseq_core #(
  parameter int PC_W = 10,
  parameter int D_W  = 16
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  input  wire logic [3:0]        i_prog_ctl,
  input  wire logic [PC_W-1:0]   i_target,
  input  wire logic [4:0]        i_cc_sel,
  input  wire logic [1:0]        i_case_group,
  input  wire logic [1:0]        i_data_op,
  input  wire logic              i_two_operand,
  input  wire logic [2:0]        i_dest_class,
  input  wire logic              i_src_is_reg,
  input  wire logic [D_W-1:0]    i_src_value,
  input  wire logic [D_W-1:0]    i_gen_value,
  input  wire logic [D_W-1:0]    i_out_ctl,
  input  wire logic [PC_W-1:0]   i_loop_counter,
  input  wire logic [PC_W-1:0]   i_fifo_head,
  input  wire logic              i_fifo_empty,
  input  wire logic [PC_W-1:0]   i_stack_top,
  input  wire logic              i_stack_full,
  input  wire logic              i_mode_int_en,
  input  wire logic [7:0]        i_int_active,
  input  wire logic [7:0]        i_user_cond,
  input  wire logic [3:0]        i_fifo_status,
  output logic [PC_W-1:0]        o_pc,
  output logic [D_W-1:0]         o_gen_result,
  output logic                   o_gen_write,
  output logic [D_W-1:0]         o_dout,
  output logic [D_W-1:0]         o_ach,
  output logic [D_W-1:0]         o_acl,
  output logic [D_W-1:0]         o_bc,
  output logic [D_W-1:0]         o_out_ctl,
  output logic [3:0]             o_arith_flags,
  output logic                   o_aco,
  output logic                   o_dor,
  output logic                   o_bcz,
  output logic                   o_fifo_pop,
  output logic                   o_operand_error
);

  // Pin inputs cross from outside; two flops before any logic reads them
  logic [7:0] user_m, user_s, int_m, int_s;
  logic [3:0] fst_m, fst_s;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      user_m <= 8'h00;
      user_s <= 8'h00;
      int_m  <= 8'h00;
      int_s  <= 8'h00;
      fst_m  <= 4'h0;
      fst_s  <= 4'h0;
    end else if (i_ce) begin
      user_m <= i_user_cond;
      user_s <= user_m;
      int_m  <= i_int_active;
      int_s  <= int_m;
      fst_m  <= i_fifo_status;
      fst_s  <= fst_m;
    end
  end

  pfseq_pkg::pfseq_regs_t r, next_r;

  logic [D_W-1:0] operand, result;
  logic [D_W:0]   sum;
  logic [3:0]     case_sel;
  logic           int_any, cc_true;
  logic [3:0]     jpi_off;
  logic [PC_W-1:0] pc_seq;

  // Operand: one-operand form uses destination, two-operand uses source
  always_comb begin
    operand = i_src_value;
    if (!i_two_operand) begin
      case (i_dest_class)
        `PFSEQ_DST_DOUT: operand = r.dout;
        `PFSEQ_DST_ACH:  operand = r.accumulator_high;
        `PFSEQ_DST_ACL:  operand = r.accumulator_low;
        `PFSEQ_DST_BC:   operand = r.bc;
        `PFSEQ_DST_Q:    operand = r.gen_q;
        default:         operand = i_gen_value;
      endcase
    end
  end

  assign sum = {1'b0, operand} + {{D_W{1'b0}}, 1'b1};

  always_comb begin
    case (i_data_op)
      `PFSEQ_OP_INV: result = ~operand;
      `PFSEQ_OP_INC: result = sum[D_W-1:0];
      default:       result = operand;
    endcase
  end

  // Either the source or the destination must be general or Q
  assign o_operand_error = (i_data_op != `PFSEQ_OP_NOP) && !i_src_is_reg &&
    (i_dest_class != `PFSEQ_DST_GEN) && (i_dest_class != `PFSEQ_DST_Q);

  // Case selector per group
  always_comb begin
    case (i_case_group)
      2'd0:    case_sel = user_s[3:0];
      2'd1:    case_sel = user_s[7:4];
      2'd2:    case_sel = {int_any, r.f_bcz, fst_s[0], fst_s[1]};
      default: case_sel = {r.f_z, r.f_o, r.f_s, r.f_cy};
    endcase
  end

  assign int_any = |int_s;

  // Lowest source number wins when several are active
  always_comb begin
    jpi_off = `PFSEQ_JPI_IDLE;
    for (int n = 7; n >= 0; n--) begin
      if (int_s[n]) begin
        jpi_off = `PFSEQ_JPI_BASE | 4'(n);
      end
    end
  end

  always_comb begin
    case (i_cc_sel)
      `PFSEQ_CC_INTERRUPT_PENDING_FLAG: cc_true = int_any;
      `PFSEQ_CC_BCZ:  cc_true = r.f_bcz;
      `PFSEQ_CC_FA:   cc_true = fst_s[0];
      `PFSEQ_CC_FB:   cc_true = fst_s[1];
      `PFSEQ_CC_Z:    cc_true = r.f_z;
      `PFSEQ_CC_O:    cc_true = r.f_o;
      `PFSEQ_CC_S:    cc_true = r.f_s;
      `PFSEQ_CC_CY:   cc_true = r.f_cy;
      `PFSEQ_CC_ACO:  cc_true = r.f_aco;
      `PFSEQ_CC_FC:   cc_true = fst_s[2];
      `PFSEQ_CC_FD:   cc_true = fst_s[3];
      `PFSEQ_CC_STACK_FULL_FLAG: cc_true = i_stack_full;
      `PFSEQ_CC_DOR:  cc_true = r.f_dor;
      default: cc_true = (i_cc_sel[4:3] == 2'b10) && user_s[i_cc_sel[2:0]];
    endcase
  end

  // A case entry without a jump simply falls to the next word
  assign pc_seq = r.pc + PC_W'(1);

  always_comb begin
    next_r          = r;
    next_r.fifo_pop = 1'b0;
    next_r.out_ctl  = i_out_ctl;
    next_r.pc       = pc_seq;
    case (i_prog_ctl)
      `PFSEQ_PC_JMP:     next_r.pc = i_target;
      `PFSEQ_PC_JMP_LC:  next_r.pc = i_loop_counter;
      `PFSEQ_PC_JMP_FIFO: begin
        if (!i_fifo_empty) begin
          next_r.pc       = i_fifo_head;
          next_r.fifo_pop = 1'b1;
        end
      end
      `PFSEQ_PC_JMP_TOS: next_r.pc = i_stack_top;
      `PFSEQ_PC_CONDITIONAL_JUMP_OP:  if (cc_true) next_r.pc = i_target;
      `PFSEQ_PC_INVERSE_CONDITIONAL_JUMP_OP: if (!cc_true) next_r.pc = i_target;
      `PFSEQ_PC_CASE:
        next_r.pc = {i_target[PC_W-1:4], case_sel};
      `PFSEQ_PC_JPI: begin
        if (!i_mode_int_en) begin
          next_r.pc = {i_target[PC_W-1:4], jpi_off};
        end
      end
      default: next_r.pc = pc_seq;
    endcase
    // Jumps alone leave every flag as it was
    if (i_data_op != `PFSEQ_OP_NOP) begin
      next_r.f_z  = (result == '0);
      next_r.f_s  = result[D_W-1];
      next_r.f_cy = (i_data_op == `PFSEQ_OP_INC) ? sum[D_W] : 1'b0;
      next_r.f_o  = (i_data_op == `PFSEQ_OP_INC) &&
                    (operand == {1'b0, {(D_W-1){1'b1}}});
      case (i_dest_class)
        `PFSEQ_DST_DOUT: begin
          next_r.dout  = result;
          next_r.f_dor = 1'b1;
        end
        `PFSEQ_DST_ACH: begin
          next_r.accumulator_high   = result;
          next_r.f_aco = next_r.f_o;
        end
        `PFSEQ_DST_ACL: begin
          next_r.accumulator_low   = result;
          next_r.f_aco = next_r.f_cy;
        end
        `PFSEQ_DST_BC: begin
          next_r.bc    = result;
          next_r.f_bcz = (result == '0);
        end
        `PFSEQ_DST_Q: next_r.gen_q = result;
        default: next_r.gen_q = r.gen_q;
      endcase
    end
    case (r.state)
      pfseq_pkg::PFSEQ_ST_RUN:  next_r.state = pfseq_pkg::PFSEQ_ST_RUN;
      default:                  next_r.state = pfseq_pkg::PFSEQ_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r       <= '0;
      r.state <= pfseq_pkg::PFSEQ_ST_HALT;
      r.pc    <= `PFSEQ_PC_RESET;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_pc          = r.pc;
  assign o_gen_result  = result;
  assign o_gen_write   = (i_data_op != `PFSEQ_OP_NOP) &&
                         (i_dest_class == `PFSEQ_DST_GEN);
  assign o_dout        = r.dout;
  assign o_ach         = r.accumulator_high;
  assign o_acl         = r.accumulator_low;
  assign o_bc          = r.bc;
  assign o_out_ctl     = r.out_ctl;
  assign o_arith_flags = {r.f_z, r.f_cy, r.f_s, r.f_o};
  assign o_aco         = r.f_aco;
  assign o_dor         = r.f_dor;
  assign o_bcz         = r.f_bcz;
  assign o_fifo_pop    = r.fifo_pop;

  property p_jmp_label;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JMP) |=> (o_pc == $past(i_target));
  endproperty
  a_jmp_label: assert property (p_jmp_label)
    else $error("label jump target wrong");

  property p_tos;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JMP_TOS) |=>
      (o_pc == $past(i_stack_top));
  endproperty
  a_tos: assert property (p_tos)
    else $error("stack jump target wrong");

  property p_case_low;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_CASE) |=>
      (o_pc[PC_W-1:4] == $past(i_target[PC_W-1:4]));
  endproperty
  a_case_low: assert property (p_case_low)
    else $error("case jump left its block");

  property p_jpi_idle;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JPI && !i_mode_int_en && !int_any)
      |=> (o_pc[3:0] == 4'h0);
  endproperty
  a_jpi_idle: assert property (p_jpi_idle)
    else $error("idle priority jump not to first entry");

  property p_jpi_act;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JPI && !i_mode_int_en && int_any)
      |=> o_pc[3];
  endproperty
  a_jpi_act: assert property (p_jpi_act)
    else $error("active priority jump outside last eight");

  property p_inverse_conditional_jump_op;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_INVERSE_CONDITIONAL_JUMP_OP && cc_true) |=>
      (o_pc == $past(r.pc) + PC_W'(1));
  endproperty
  a_inverse_conditional_jump_op: assert property (p_inverse_conditional_jump_op)
    else $error("inverse jump taken on true code");

  property p_flags_hold;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_data_op == `PFSEQ_OP_NOP) |=> $stable(o_arith_flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed without data op");

  property p_inv_dout;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_data_op == `PFSEQ_OP_INV && i_two_operand &&
     i_dest_class == `PFSEQ_DST_DOUT) |=>
      (o_dout == ~$past(i_src_value)) && o_dor;
  endproperty
  a_inv_dout: assert property (p_inv_dout)
    else $error("complement to data output wrong");

  property p_conditional_jump_op;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_CONDITIONAL_JUMP_OP && cc_true) |=>
      (o_pc == $past(i_target));
  endproperty
  a_conditional_jump_op: assert property (p_conditional_jump_op)
    else $error("conditional jump not taken on true code");

  property p_lc_ptr;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JMP_LC) |=>
      (o_pc == $past(i_loop_counter));
  endproperty
  a_lc_ptr: assert property (p_lc_ptr)
    else $error("loop pointer jump target wrong");

  property p_fifo_jump;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JMP_FIFO && !i_fifo_empty) |=>
      (o_pc == $past(i_fifo_head)) && o_fifo_pop;
  endproperty
  a_fifo_jump: assert property (p_fifo_jump)
    else $error("fifo jump target or pop wrong");

  property p_jpi_masked;
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && i_prog_ctl == `PFSEQ_PC_JPI && i_mode_int_en) |=>
      (o_pc == $past(r.pc) + PC_W'(1));
  endproperty
  a_jpi_masked: assert property (p_jpi_masked)
    else $error("priority jump acted with interrupts enabled");

endmodule

`default_nettype wire

//--- pfseq_prog_mem.sv
// Program memory model: one instruction word per location, read by pc.
// Assumes the bench fills the words array before reset is released.
`timescale 1ns/100ps
`default_nettype none

module pfseq_prog_mem (
  input  wire logic        i_clock,
  input  wire logic [9:0]  i_pc,
  output logic [3:0]       o_prog_ctl,
  output logic [9:0]       o_target,
  output logic [4:0]       o_cc_sel,
  output logic [1:0]       o_case_group,
  output logic [1:0]       o_data_op,
  output logic             o_two_operand,
  output logic [2:0]       o_dest_class,
  output logic             o_src_is_reg,
  output logic [15:0]      o_out_ctl
);
  logic [42:0] words [0:1023];
  logic [42:0] word;

  // Unwritten locations read as a plain sequential step with no data op
  initial begin
    for (int a = 0; a < 1024; a++) begin
      words[a] = 43'h0;
    end
  end

  // Fetch on the falling edge so the word is steady before the next rise
  always_ff @(negedge i_clock) begin
    word <= words[i_pc];
  end

  // Control, data and output fields leave together in one word
  assign {o_prog_ctl, o_target, o_cc_sel, o_case_group, o_data_op,
          o_two_operand, o_dest_class, o_out_ctl} = word;
  // Every test word names a register source
  assign o_src_is_reg = 1'b1;
endmodule

`default_nettype wire

//--- program_flow_sequencer_bench.sv
// Bench for the program flow sequencer: runs a fixed program, checks pc.
// Assumes pfseq_core and the pfseq_prog_mem memory model.
`timescale 1ns/100ps
`default_nettype none
`include "pfseq_defs.svh"

module program_flow_sequencer_bench;
  logic        clk, rst_b, fempty, int_en, two, sreg, ce, stack_full_flag, src_bad;
  logic [3:0]  ctl, flags, fst;
  logic [9:0]  tgt, lc, fhead, stop, pc;
  logic [4:0]  cc;
  logic [1:0]  grp, op;
  logic [2:0]  dst;
  logic [7:0]  int_act, user;
  logic [15:0] src, gen, outw, gres, dout, accumulator_high, accumulator_low, bc, octl;
  logic        gwr, accumulator_overflow, data_output_flag, block_count_zero, pop, oerr;
  integer      failures, checks_done;

  pfseq_prog_mem prog (.i_clock(clk), .i_pc(pc), .o_prog_ctl(ctl),
    .o_target(tgt), .o_cc_sel(cc), .o_case_group(grp), .o_data_op(op),
    .o_two_operand(two), .o_dest_class(dst), .o_src_is_reg(sreg),
    .o_out_ctl(outw));

  pfseq_core dut (.i_clock(clk), .i_rst_b(rst_b), .i_ce(ce),
    .i_prog_ctl(ctl), .i_target(tgt), .i_cc_sel(cc), .i_case_group(grp),
    .i_data_op(op), .i_two_operand(two), .i_dest_class(dst),
    .i_src_is_reg(sreg && !src_bad), .i_src_value(src),
    .i_gen_value(gen),
    .i_out_ctl(outw), .i_loop_counter(lc), .i_fifo_head(fhead),
    .i_fifo_empty(fempty), .i_stack_top(stop), .i_stack_full(stack_full_flag),
    .i_mode_int_en(int_en), .i_int_active(int_act), .i_user_cond(user),
    .i_fifo_status(fst), .o_pc(pc), .o_gen_result(gres),
    .o_gen_write(gwr), .o_dout(dout), .o_ach(accumulator_high), .o_acl(accumulator_low),
    .o_bc(bc),
    .o_out_ctl(octl), .o_arith_flags(flags), .o_aco(accumulator_overflow), .o_dor(data_output_flag),
    .o_bcz(block_count_zero), .o_fifo_pop(pop), .o_operand_error(oerr));

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One instruction: wait its edge, check pc, return on the falling edge
  task automatic step(input logic [9:0] e);
    @(posedge clk);
    #1;
    cmp({6'h0, pc}, {6'h0, e});
    $display("test at pc %h done", e);
    @(negedge clk);
  endtask

  task automatic put(input logic [9:0] a, input logic [3:0] c,
    input logic [9:0] t, input logic [4:0] s, input logic [1:0] g,
    input logic [1:0] o, input logic w, input logic [2:0] d,
    input logic [15:0] v);
    prog.words[a] = {c, t, s, g, o, w, d, v};
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (500) @(posedge clk);
    failures++;
    $display("BAD t=%0t got %h exp %h", $time, pc, 10'h2C0);
    summarize();
  end

  initial begin
    failures = 0;
    checks_done = 0;
    rst_b = 1'b0;
    src = 16'h7FFF;
    gen = 16'h1234;
    lc = 10'h3FF;
    fhead = 10'h2AB;
    fempty = 1'b0;
    stop = 10'h0F0;
    int_en = 1'b0;
    int_act = 8'h00;
    user = 8'hAB;
    ce = 1'b1;
    fst = 4'h5;
    stack_full_flag = 1'b1;
    src_bad = 1'b0;
    // Let the memory model clear its words before the program goes in
    #1;
    // Case bases keep their low four bits clear
    put(10'h000, `PFSEQ_PC_JMP, 10'h055, 5'h00, 2'h0, `PFSEQ_OP_INC, 1'b1,
        `PFSEQ_DST_ACH, 16'hA5A5);
    put(10'h055, `PFSEQ_PC_CASE, 10'h200, 5'h00, 2'h3, `PFSEQ_OP_NOP, 1'b0,
        `PFSEQ_DST_GEN, 16'h0000);
    put(10'h206, `PFSEQ_PC_CONT, 10'h000, 5'h00, 2'h0, `PFSEQ_OP_INV, 1'b0,
        `PFSEQ_DST_GEN, 16'h0000);
    put(10'h207, `PFSEQ_PC_JMP_LC, 10'h000, 5'h00, 2'h0, `PFSEQ_OP_INV,
        1'b1, `PFSEQ_DST_DOUT, 16'h0000);
    put(10'h3FF, `PFSEQ_PC_CONDITIONAL_JUMP_OP, 10'h100, `PFSEQ_CC_Z, 2'h0, 2'h0, 1'b0,
        3'h0, 16'h0000);
    put(10'h100, `PFSEQ_PC_INVERSE_CONDITIONAL_JUMP_OP, 10'h180, `PFSEQ_CC_Z, 2'h0, 2'h0, 1'b0,
        3'h0, 16'h0000);
    put(10'h101, `PFSEQ_PC_CONDITIONAL_JUMP_OP, 10'h120, 5'h13, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h120, `PFSEQ_PC_INVERSE_CONDITIONAL_JUMP_OP, 10'h140, `PFSEQ_CC_S, 2'h0, 2'h0, 1'b0,
        3'h0, 16'h0000);
    put(10'h140, `PFSEQ_PC_JPI, 10'h300, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h302, `PFSEQ_PC_JPI, 10'h310, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h31A, `PFSEQ_PC_JPI, 10'h320, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h31B, `PFSEQ_PC_JMP_FIFO, 10'h000, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h2AB, `PFSEQ_PC_JMP_TOS, 10'h000, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h0F0, `PFSEQ_PC_CASE, 10'h200, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h20B, `PFSEQ_PC_CASE, 10'h240, 5'h00, 2'h1, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h24A, `PFSEQ_PC_CONT, 10'h000, 5'h00, 2'h0, `PFSEQ_OP_INC, 1'b1,
        `PFSEQ_DST_BC, 16'h0000);
    put(10'h24B, `PFSEQ_PC_JMP_FIFO, 10'h000, 5'h00, 2'h0, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h301, `PFSEQ_PC_CONT, 10'h000, 5'h00, 2'h0, `PFSEQ_OP_INC, 1'b0,
        `PFSEQ_DST_ACL, 16'h0000);
    put(10'h24C, `PFSEQ_PC_CASE, 10'h260, 5'h00, 2'h2, 2'h0, 1'b0, 3'h0,
        16'h0000);
    put(10'h26E, `PFSEQ_PC_CONDITIONAL_JUMP_OP, 10'h280, `PFSEQ_CC_STACK_FULL_FLAG, 2'h0, 2'h0, 1'b0,
        3'h0, 16'h0000);
    put(10'h280, `PFSEQ_PC_INVERSE_CONDITIONAL_JUMP_OP, 10'h2C0, `PFSEQ_CC_FD, 2'h0, 2'h0, 1'b0,
        3'h0, 16'h0000);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    step(10'h055);
    cmp(accumulator_high, 16'h8000);
    cmp({11'h0, flags, accumulator_overflow}, 16'h0007);
    cmp(octl, 16'hA5A5);
    step(10'h206);
    cmp({12'h0, flags}, 16'h0003);
    src = 16'hFFFF;
    #1;
    cmp(gres, 16'hEDCB);
    cmp({15'h0, gwr}, 16'h0001);
    cmp({15'h0, oerr}, 16'h0000);
    step(10'h207);
    cmp({13'h0, flags[3:1]}, 16'h0001);
    src_bad = 1'b1;
    #1;
    cmp({15'h0, oerr}, 16'h0001);
    step(10'h3FF);
    src_bad = 1'b0;
    cmp(dout, 16'h0000);
    cmp({12'h0, flags[3:1], data_output_flag}, 16'h0009);
    step(10'h100);
    step(10'h101);
    step(10'h120);
    step(10'h140);
    int_act = 8'h24;
    step(10'h300);
    step(10'h301);
    step(10'h302);
    cmp(accumulator_low, 16'h0001);
    cmp({11'h0, flags, accumulator_overflow}, 16'h0000);
    step(10'h31A);
    int_en = 1'b1;
    step(10'h31B);
    step(10'h2AB);
    cmp({15'h0, pop}, 16'h0001);
    step(10'h0F0);
    step(10'h20B);
    step(10'h24A);
    step(10'h24B);
    cmp({12'h0, flags[3:1], block_count_zero}, 16'h000D);
    cmp(bc, 16'h0000);
    fempty = 1'b1;
    step(10'h24C);
    cmp({15'h0, pop}, 16'h0000);
    ce = 1'b0;
    step(10'h24C);
    ce = 1'b1;
    step(10'h26E);
    step(10'h280);
    step(10'h2C0);
    summarize();
  end
endmodule

`default_nettype wire
